// File: rtl/tqm_defines.svh
// Constants for the transmit queue frame manager: offsets, fields, reset values, sizes.
`ifndef TQM_DEFINES_SVH
`define TQM_DEFINES_SVH

// Register byte offsets on the indirect host bus.
`define TQM_OFS_TX_CONTROL       8'h70
`define TQM_OFS_TX_FRAME_STATUS  8'h72
`define TQM_OFS_TX_FREE_MEMORY   8'h78
`define TQM_OFS_TX_QUEUE_COMMAND 8'h80
`define TQM_OFS_RX_QUEUE_COMMAND 8'h82
`define TQM_OFS_TX_DATA_POINTER  8'h84
`define TQM_OFS_INTERRUPT_ENABLE 8'h90
`define TQM_OFS_INTERRUPT_STATUS 8'h92
`define TQM_OFS_TX_SPACE_REQUEST 8'h9E
`define TQM_OFS_DATA_PORT        8'hC0

// Reset values.
`define TQM_RST_WORD             16'h0000
`define TQM_RST_ADDR             8'h00
`define TQM_RST_PTR              12'h000
`define TQM_RST_USED             13'h0000
`define TQM_RST_LEN              11'h000

// Field positions.
`define TQM_TXC_ENABLE           0
`define TQM_TXC_OPT_MSB          8
`define TQM_TXQ_ENQUEUE          0
`define TQM_TXQ_SPACE_ARM        1
`define TQM_RXQ_WINDOW           3
`define TQM_PTR_AUTOINC          14
`define TQM_PTR_MSB              10
`define TQM_IRQ_TX_DONE          15
`define TQM_IRQ_TX_SPACE         6
`define TQM_IER_TX_DONE          14
`define TQM_CW_IRQ_ON_DONE       15
`define TQM_CW_ID_MSB            5
`define TQM_BC_MSB               10
`define TQM_ST_DONE              15
`define TQM_ST_BUSY              13
`define TQM_SD_ADDR_MSB          7
`define TQM_SD_ADDR_LSB          2
`define TQM_SD_BE_HI_MSB         15
`define TQM_SD_BE_HI_LSB         14

// Memory geometry: 6 KB held as 16-bit words.
`define TQM_MEM_WORDS            13'h0C00
`define TQM_MEM_BYTES            13'h1800
`define TQM_MAX_FRAME_BYTES      11'h07D0
`define TQM_HDR_WORDS            12'h002
`define TQM_BC_WORD_INDEX        10'h001
`define TQM_PTR_STEP             11'h002
`define TQM_ONE_WORD             12'h001
`define TQM_ONE_LEFT             11'h001
`define TQM_REQ_SHIFT            2

`endif

// File: rtl/tqm_mem.sv
// Transmit packet memory: one write port, one read port with registered data.
`timescale 1ns/10ps
module tqm_mem
    import tqm_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        we,
    input  wire tqm_idx_t    waddr,
    input  wire logic [15:0] wdata,
    input  wire tqm_idx_t    raddr,
    output logic      [15:0] rdata_r
);

    logic [15:0] mem [0:3071];

    // Storage needs no reset; a frame is only read after the host has written it.
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_r <= mem[raddr];
    end

endmodule

// File: rtl/tqm_pkg.sv
// Types shared by the transmit queue frame manager.
package tqm_pkg;

    // Sender states, Gray coded along the normal walk through a frame.
    typedef enum logic [2:0] {
        TQM_S_IDLE = 3'b000,
        TQM_S_CTRL = 3'b001,
        TQM_S_CNT  = 3'b011,
        TQM_S_LEN  = 3'b010,
        TQM_S_PUSH = 3'b110,
        TQM_S_DRD  = 3'b111,
        TQM_S_WAIT = 3'b100
    } tqm_state_e;

    typedef logic [11:0] tqm_idx_t;

endpackage

// File: rtl/tqm_top.sv
// Transmit queue frame manager: host registers, packet memory, sender and MAC stream.
`timescale 1ns/10ps
`include "tqm_defines.svh"

// Notes on behaviour
// - Control word, byte count, then frame data.
// - CRC generation enable passed to MAC side.
// - Status shows frame currently being sent.
// - Bit 15 requests completion interrupt.
// - Frame identifier reported in status register.
// - At most 2000 bytes; allocate only needed.
// - Frame bytes passed through untouched.
// - Transmit control enable and option bits.
// - Free memory in bytes, thirteen bits.
// - Enqueue bit queues frame, clears when sent.
// - Space request sets status bit six.
// - Receive command bit three opens data window.
// - Pointer auto-increments when bit 14 set.
// - Enable bits 14 and 6 gate interrupts.
// - Status bits cleared by writing one.
// - Interrupt output driven low on interrupt.
module tqm_top
    import tqm_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [15:0] sd_in,
    output logic      [15:0] sd_out,
    output logic             sd_oe_n,
    input  wire logic        cmd,
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    output logic             interrupt_out_n,
    output logic      [15:0] mac_data,
    output logic             mac_last,
    output logic             mac_valid,
    input  wire logic        mac_ready,
    output logic      [8:0]  mac_options
);

    // Index arithmetic wraps around the circular packet memory.
    function automatic tqm_idx_t wrap_add(input tqm_idx_t a, input tqm_idx_t b);
        logic [12:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s >= `TQM_MEM_WORDS) begin
            s = s - `TQM_MEM_WORDS;
        end
        return s[11:0];
    endfunction

    // Address match, used by the read mux and by every register write.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    logic [7:0]  addr_r, addr_nxt;
    logic [15:0] ctl_r, ctl_nxt, ier_r, ier_nxt, isr_r, isr_nxt;
    logic [15:0] req_r, req_nxt, rxq_r, rxq_nxt, ptr_r, ptr_nxt;
    logic [15:0] sd_out_r, sd_out_nxt;
    logic        enq_r, enq_nxt, arm_r, arm_nxt, irq_n_r, irq_n_nxt;
    logic        wr_q_r, rd_q_r;
    tqm_idx_t    commit_r, commit_nxt, rdp_r, rdp_nxt, idx_r, idx_nxt;
    tqm_idx_t    fr_words_r, fr_words_nxt, new_words;
    logic [12:0] used_r, used_nxt, free_bytes;
    logic [10:0] bc_r, bc_nxt, left_r, left_nxt, bc_clamp;
    logic [15:0] cw_r, cw_nxt;
    logic        done_r, done_nxt;
    tqm_state_e  st_r, st_nxt;
    logic        wr_evt, rd_evt, data_wr, enq_evt, frame_done, push;
    tqm_idx_t    waddr;
    logic [15:0] mem_rdata, rd_word;
    logic [16:0] fifo_r [0:1];
    logic [16:0] fifo_nxt [0:1];
    logic        f_wp_r, f_wp_nxt, f_rp_r, f_rp_nxt;
    logic [1:0]  f_cnt_r, f_cnt_nxt;
    logic        f_in_ready, f_out_fire;

    // Host strobes are sampled synchronously; an access is taken on its falling edge.
    assign wr_evt = !cs_n && !wr_n && wr_q_r;
    assign rd_evt = !cs_n && !rd_n && rd_q_r;
    // Data port writes land in memory only while the window is open.
    assign data_wr = wr_evt && !cmd && rxq_r[`TQM_RXQ_WINDOW]
                     && hit(addr_r, `TQM_OFS_DATA_PORT);
    // Host offsets are relative to the start of the frame being prepared.
    assign waddr = wrap_add(commit_r, {2'b00, ptr_r[`TQM_PTR_MSB:1]});
    // Only one frame is queued at a time; a second request is ignored.
    assign enq_evt = wr_evt && !cmd && hit(addr_r, `TQM_OFS_TX_QUEUE_COMMAND)
                     && sd_in[`TQM_TXQ_ENQUEUE] && !enq_r;
    // Clamping protects the allocation from an oversize count.
    assign bc_clamp = (bc_r > `TQM_MAX_FRAME_BYTES) ? `TQM_MAX_FRAME_BYTES : bc_r;
    assign new_words = `TQM_HDR_WORDS + (({1'b0, bc_clamp} + `TQM_ONE_WORD) >> 1);
    // Free space is reported in bytes and covers headers too.
    assign free_bytes = `TQM_MEM_BYTES - used_r;

    // Register read mux; unmapped offsets read as zero.
    always_comb begin
        rd_word = `TQM_RST_WORD;
        if (hit(addr_r, `TQM_OFS_TX_CONTROL)) begin
            rd_word = ctl_r;
        end else if (hit(addr_r, `TQM_OFS_TX_FRAME_STATUS)) begin
            // Identifier and progress of the frame on the MAC side.
            rd_word = `TQM_RST_WORD;
            rd_word[`TQM_CW_ID_MSB:0] = cw_r[`TQM_CW_ID_MSB:0];
            rd_word[`TQM_ST_BUSY] = (st_r != TQM_S_IDLE);
            rd_word[`TQM_ST_DONE] = done_r;
        end else if (hit(addr_r, `TQM_OFS_TX_FREE_MEMORY)) begin
            rd_word = {3'b000, free_bytes};
        end else if (hit(addr_r, `TQM_OFS_TX_QUEUE_COMMAND)) begin
            rd_word = {14'h0000, arm_r, enq_r};
        end else if (hit(addr_r, `TQM_OFS_RX_QUEUE_COMMAND)) begin
            rd_word = rxq_r;
        end else if (hit(addr_r, `TQM_OFS_TX_DATA_POINTER)) begin
            rd_word = ptr_r;
        end else if (hit(addr_r, `TQM_OFS_INTERRUPT_ENABLE)) begin
            rd_word = ier_r;
        end else if (hit(addr_r, `TQM_OFS_INTERRUPT_STATUS)) begin
            rd_word = isr_r;
        end else if (hit(addr_r, `TQM_OFS_TX_SPACE_REQUEST)) begin
            rd_word = req_r;
        end
    end

    // Host side register file: address phase, data phase and side effects.
    always_comb begin
        addr_nxt   = addr_r;
        ctl_nxt    = ctl_r;
        ier_nxt    = ier_r;
        isr_nxt    = isr_r;
        req_nxt    = req_r;
        rxq_nxt    = rxq_r;
        ptr_nxt    = ptr_r;
        enq_nxt    = enq_r;
        arm_nxt    = arm_r;
        bc_nxt     = bc_r;
        commit_nxt = commit_r;
        sd_out_nxt = sd_out_r;
        if (wr_evt && cmd) begin
            // Address phase: dword address plus upper half select.
            addr_nxt = {sd_in[`TQM_SD_ADDR_MSB:`TQM_SD_ADDR_LSB],
                        |sd_in[`TQM_SD_BE_HI_MSB:`TQM_SD_BE_HI_LSB], 1'b0};
        end
        if (rd_evt) begin
            // Reading with the command pin high returns the last address.
            sd_out_nxt = cmd ? {8'h00, addr_r} : rd_word;
        end
        if (wr_evt && !cmd) begin
            if (hit(addr_r, `TQM_OFS_TX_CONTROL)) begin
                ctl_nxt = sd_in;
            end
            if (hit(addr_r, `TQM_OFS_INTERRUPT_ENABLE)) begin
                ier_nxt = sd_in;
            end
            if (hit(addr_r, `TQM_OFS_INTERRUPT_STATUS)) begin
                isr_nxt = isr_r & ~sd_in;
            end
            if (hit(addr_r, `TQM_OFS_TX_SPACE_REQUEST)) begin
                req_nxt = sd_in;
            end
            if (hit(addr_r, `TQM_OFS_RX_QUEUE_COMMAND)) begin
                rxq_nxt = sd_in;
            end
            if (hit(addr_r, `TQM_OFS_TX_DATA_POINTER)) begin
                ptr_nxt = sd_in;
            end
            if (hit(addr_r, `TQM_OFS_TX_QUEUE_COMMAND) && sd_in[`TQM_TXQ_SPACE_ARM]) begin
                arm_nxt = 1'b1;
            end
        end
        if (data_wr) begin
            // The byte count word is snooped so the frame can be sized.
            if (ptr_r[`TQM_PTR_MSB:1] == `TQM_BC_WORD_INDEX) begin
                bc_nxt = sd_in[`TQM_BC_MSB:0];
            end
            if (ptr_r[`TQM_PTR_AUTOINC]) begin
                ptr_nxt[`TQM_PTR_MSB:0] = ptr_r[`TQM_PTR_MSB:0] + `TQM_PTR_STEP;
            end
        end
        if (enq_evt) begin
            enq_nxt    = 1'b1;
            commit_nxt = wrap_add(commit_r, new_words);
        end
        // Hardware sets win over a same-cycle host clear.
        if (frame_done) begin
            enq_nxt = 1'b0;
            if (cw_r[`TQM_CW_IRQ_ON_DONE]) begin
                isr_nxt[`TQM_IRQ_TX_DONE] = 1'b1;
            end
        end
        if (arm_r && ({5'h00, free_bytes} >= {req_r, 2'b00})) begin
            arm_nxt = 1'b0;
            isr_nxt[`TQM_IRQ_TX_SPACE] = 1'b1;
        end
        // Held low while any enabled status bit stays set.
        irq_n_nxt = !((isr_nxt[`TQM_IRQ_TX_DONE] && ier_r[`TQM_IER_TX_DONE])
                      || (isr_nxt[`TQM_IRQ_TX_SPACE] && ier_r[`TQM_IRQ_TX_SPACE]));
    end

    // Space accounting: taken on enqueue, returned once the frame is sent.
    always_comb begin
        used_nxt = used_r;
        if (enq_evt) begin
            used_nxt = used_nxt + {new_words, 1'b0};
        end
        if (frame_done) begin
            used_nxt = used_nxt - {fr_words_nxt, 1'b0};
        end
    end

    // Sender: reads header, then streams the data words untouched.
    always_comb begin
        st_nxt       = st_r;
        idx_nxt      = idx_r;
        cw_nxt       = cw_r;
        left_nxt     = left_r;
        fr_words_nxt = fr_words_r;
        rdp_nxt      = rdp_r;
        done_nxt     = done_r;
        push         = 1'b0;
        frame_done   = 1'b0;
        case (st_r)
            TQM_S_IDLE: begin
                // Transmit block enable gates the start of each frame.
                if (ctl_r[`TQM_TXC_ENABLE] && (rdp_r != commit_r)) begin
                    idx_nxt  = rdp_r;
                    done_nxt = 1'b0;
                    st_nxt   = TQM_S_CTRL;
                end
            end
            TQM_S_CTRL: begin
                idx_nxt = wrap_add(idx_r, `TQM_ONE_WORD);
                st_nxt  = TQM_S_CNT;
            end
            TQM_S_CNT: begin
                cw_nxt  = mem_rdata;
                idx_nxt = wrap_add(idx_r, `TQM_ONE_WORD);
                st_nxt  = TQM_S_LEN;
            end
            TQM_S_LEN: begin
                left_nxt = (mem_rdata[`TQM_BC_MSB:0] > `TQM_MAX_FRAME_BYTES)
                           ? (`TQM_MAX_FRAME_BYTES >> 1)
                           : (mem_rdata[`TQM_BC_MSB:0] + `TQM_ONE_LEFT) >> 1;
                fr_words_nxt = `TQM_HDR_WORDS + {1'b0, left_nxt};
                if (left_nxt == `TQM_RST_LEN) begin
                    // A zero count is not allowed; release the slot without sending.
                    frame_done = 1'b1;
                    rdp_nxt    = wrap_add(rdp_r, fr_words_nxt);
                    done_nxt   = 1'b1;
                    st_nxt     = TQM_S_IDLE;
                end else begin
                    st_nxt = TQM_S_PUSH;
                end
            end
            TQM_S_PUSH: begin
                if (f_in_ready) begin
                    push     = 1'b1;
                    left_nxt = left_r - `TQM_ONE_LEFT;
                    idx_nxt  = wrap_add(idx_r, `TQM_ONE_WORD);
                    st_nxt   = (left_r == `TQM_ONE_LEFT) ? TQM_S_WAIT : TQM_S_DRD;
                end
            end
            TQM_S_DRD: begin
                st_nxt = TQM_S_PUSH;
            end
            TQM_S_WAIT: begin
                // Finished only when the MAC has taken the last word.
                if (f_out_fire && fifo_r[f_rp_r][16]) begin
                    frame_done = 1'b1;
                    rdp_nxt    = wrap_add(rdp_r, fr_words_r);
                    done_nxt   = 1'b1;
                    st_nxt     = TQM_S_IDLE;
                end
            end
            default: begin
                st_nxt = TQM_S_IDLE;
            end
        endcase
    end

    // Two-entry buffer toward the MAC; a stall there stalls the sender.
    assign f_in_ready = (f_cnt_r != 2'd2);
    assign f_out_fire = (f_cnt_r != 2'd0) && mac_ready;
    always_comb begin
        fifo_nxt[0] = fifo_r[0];
        fifo_nxt[1] = fifo_r[1];
        f_wp_nxt    = f_wp_r;
        f_rp_nxt    = f_rp_r;
        if (push) begin
            fifo_nxt[f_wp_r] = {(left_r == `TQM_ONE_LEFT), mem_rdata};
            f_wp_nxt         = !f_wp_r;
        end
        if (f_out_fire) begin
            f_rp_nxt = !f_rp_r;
        end
        f_cnt_nxt = f_cnt_r + {1'b0, push} - {1'b0, f_out_fire};
    end

    assign mac_valid   = (f_cnt_r != 2'd0);
    assign mac_data    = fifo_r[f_rp_r][15:0];
    assign mac_last    = fifo_r[f_rp_r][16];
    // Padding, CRC and checksum options go to the MAC as set.
    assign mac_options = ctl_r[`TQM_TXC_OPT_MSB:0];
    assign sd_out      = sd_out_r;
    assign sd_oe_n     = !(!cs_n && !rd_n);
    assign interrupt_out_n = irq_n_r;

    // All state registers; synchronous reset.
    always_ff @(posedge mclk) begin
        if (rst) begin
            addr_r     <= `TQM_RST_ADDR;
            ctl_r      <= `TQM_RST_WORD;
            ier_r      <= `TQM_RST_WORD;
            isr_r      <= `TQM_RST_WORD;
            req_r      <= `TQM_RST_WORD;
            rxq_r      <= `TQM_RST_WORD;
            ptr_r      <= `TQM_RST_WORD;
            sd_out_r   <= `TQM_RST_WORD;
            cw_r       <= `TQM_RST_WORD;
            enq_r      <= 1'b0;
            arm_r      <= 1'b0;
            done_r     <= 1'b0;
            irq_n_r    <= 1'b1;
            wr_q_r     <= 1'b1;
            rd_q_r     <= 1'b1;
            commit_r   <= `TQM_RST_PTR;
            rdp_r      <= `TQM_RST_PTR;
            idx_r      <= `TQM_RST_PTR;
            fr_words_r <= `TQM_RST_PTR;
            used_r     <= `TQM_RST_USED;
            bc_r       <= `TQM_RST_LEN;
            left_r     <= `TQM_RST_LEN;
            st_r       <= TQM_S_IDLE;
            fifo_r[0]  <= 17'h0_0000;
            fifo_r[1]  <= 17'h0_0000;
            f_wp_r     <= 1'b0;
            f_rp_r     <= 1'b0;
            f_cnt_r    <= 2'd0;
        end else begin
            addr_r     <= addr_nxt;
            ctl_r      <= ctl_nxt;
            ier_r      <= ier_nxt;
            isr_r      <= isr_nxt;
            req_r      <= req_nxt;
            rxq_r      <= rxq_nxt;
            ptr_r      <= ptr_nxt;
            sd_out_r   <= sd_out_nxt;
            cw_r       <= cw_nxt;
            enq_r      <= enq_nxt;
            arm_r      <= arm_nxt;
            done_r     <= done_nxt;
            irq_n_r    <= irq_n_nxt;
            wr_q_r     <= cs_n || wr_n;
            rd_q_r     <= cs_n || rd_n;
            commit_r   <= commit_nxt;
            rdp_r      <= rdp_nxt;
            idx_r      <= idx_nxt;
            fr_words_r <= fr_words_nxt;
            used_r     <= used_nxt;
            bc_r       <= bc_nxt;
            left_r     <= left_nxt;
            st_r       <= st_nxt;
            fifo_r[0]  <= fifo_nxt[0];
            fifo_r[1]  <= fifo_nxt[1];
            f_wp_r     <= f_wp_nxt;
            f_rp_r     <= f_rp_nxt;
            f_cnt_r    <= f_cnt_nxt;
        end
    end

    tqm_mem u_mem (
        .mclk    (mclk),
        .we      (data_wr),
        .waddr   (waddr),
        .wdata   (sd_in),
        .raddr   (idx_r),
        .rdata_r (mem_rdata)
    );

endmodule

// File: verif/testbench.sv
// Self-checking bench: host bus tasks send frames, space notices and interrupt clears.
`timescale 1ns/10ps
`include "tqm_defines.svh"
module testbench;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        cmd = 1'b0;
    logic        cs_n = 1'b1;
    logic        rd_n = 1'b1;
    logic        wr_n = 1'b1;
    logic [15:0] sd_in = 16'h0000;
    logic [1:0]  pace = 2'h0;
    logic [15:0] sd_out, mac_data, q;
    logic        sd_oe_n, interrupt_out_n, mac_last, mac_valid, mac_ready;
    logic [8:0]  mac_options;
    int          error_cnt = 0;
    int          n_compared = 0;

    always #2 mclk = ~mclk;

    tqm_top uut (.mclk(mclk), .rst(rst), .sd_in(sd_in), .sd_out(sd_out), .sd_oe_n(sd_oe_n),
        .cmd(cmd), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .interrupt_out_n(interrupt_out_n),
        .mac_data(mac_data), .mac_last(mac_last), .mac_valid(mac_valid),
        .mac_ready(mac_ready), .mac_options(mac_options));
    tqm_sink snk (.mclk(mclk), .pace(pace), .mac_valid(mac_valid), .mac_data(mac_data),
        .mac_last(mac_last), .mac_ready(mac_ready));

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic hang(string name);
        error_cnt++;
        $display("BAD %s expected done seen timeout", name);
        stop_test();
    endtask
    // One strobe; it goes high again for an edge so the next access is taken.
    task automatic strobe(logic c, logic [15:0] d);
        cmd = c;
        sd_in = d;
        cs_n = 1'b0;
        wr_n = 1'b0;
        tick();
        cs_n = 1'b1;
        wr_n = 1'b1;
        tick();
    endtask
    // Address phase carries byte enables for the upper or lower half of the dword.
    task automatic addr(logic [7:0] a);
        strobe(1'b1, {a[1] ? 4'hC : 4'h3, 4'h0, a[7:2], 2'b00});
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] d);
        addr(a);
        strobe(1'b0, d);
    endtask
    task automatic rchk(string name, logic [7:0] a, logic [15:0] mask, logic [15:0] exp);
        addr(a);
        cmd = 1'b0;
        cs_n = 1'b0;
        rd_n = 1'b0;
        tick();
        tick();
        q = sd_out;
        cs_n = 1'b1;
        rd_n = 1'b1;
        tick();
        chk(name, exp, q & mask);
    endtask

    // Builds a frame in the data window, queues it with the sink stalled, then drains it.
    task automatic send(logic [15:0] cw, logic [10:0] bc, logic [1:0] p);
        int nw;
        nw = (bc + 1) / 2;
        pace = 2'h0;
        snk.cnt = 0;
        snk.last_at = -1;
        wr(`TQM_OFS_RX_QUEUE_COMMAND, 16'h0008);
        wr(`TQM_OFS_TX_DATA_POINTER, 16'h4000);
        wr(`TQM_OFS_DATA_PORT, cw);
        wr(`TQM_OFS_DATA_PORT, {5'h00, bc});
        for (int i = 0; i < nw; i++) wr(`TQM_OFS_DATA_PORT, 16'hA500 + i[15:0]);
        wr(`TQM_OFS_TX_QUEUE_COMMAND, 16'h0001);
        rchk("free", `TQM_OFS_TX_FREE_MEMORY, 16'h1FFF, 16'h1800 - 16'(4 + 2 * nw));
        rchk("queued", `TQM_OFS_TX_QUEUE_COMMAND, 16'h0001, 16'h0001);
        pace = p;
        for (int i = 0; i < 5000 && snk.last_at < 0; i++) tick();
        if (snk.last_at < 0) hang("frame");
        chk("words", nw[15:0], snk.cnt[15:0]);
        chk("last", nw[15:0] - 16'h0001, snk.last_at[15:0]);
        for (int i = 0; i < nw; i++) chk("data", 16'hA500 + i[15:0], snk.got[i]);
        rchk("fid", `TQM_OFS_TX_FRAME_STATUS, 16'h003F, {10'h000, cw[5:0]});
        rchk("free", `TQM_OFS_TX_FREE_MEMORY, 16'h1FFF, 16'h1800);
        rchk("done", `TQM_OFS_TX_QUEUE_COMMAND, 16'h0001, 16'h0000);
        rchk("isr", `TQM_OFS_INTERRUPT_STATUS, 16'h8000, cw & 16'h8000);
        chk("irq", {15'h0000, !cw[15]}, {15'h0000, interrupt_out_n});
        wr(`TQM_OFS_INTERRUPT_STATUS, 16'hFFFF);
        tick();
        chk("irq off", 16'h0001, {15'h0000, interrupt_out_n});
        $display("test frame %h done", cw);
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        #1 rst = 1'b0;
        // Reset values and a hole in the map.
        rchk("free", `TQM_OFS_TX_FREE_MEMORY, 16'hFFFF, 16'h1800);
        rchk("txc", `TQM_OFS_TX_CONTROL, 16'hFFFF, 16'h0000);
        rchk("hole", 8'h10, 16'hFFFF, 16'h0000);
        wr(`TQM_OFS_TX_CONTROL, 16'h01EF);
        chk("opts", 16'h01EF, {7'h00, mac_options});
        rchk("txc", `TQM_OFS_TX_CONTROL, 16'hFFFF, 16'h01EF);
        $display("test control done");
        wr(`TQM_OFS_INTERRUPT_ENABLE, 16'h4000);
        send(16'h8015, 11'd5, 2'h1);
        send(16'h002A, 11'd2000, 2'h2);
        // Space notice: one dword too many never fires, then fires while masked.
        wr(`TQM_OFS_INTERRUPT_ENABLE, 16'h0000);
        wr(`TQM_OFS_TX_SPACE_REQUEST, 16'h0601);
        wr(`TQM_OFS_TX_QUEUE_COMMAND, 16'h0002);
        rchk("no space", `TQM_OFS_INTERRUPT_STATUS, 16'h0040, 16'h0000);
        rchk("armed", `TQM_OFS_TX_QUEUE_COMMAND, 16'h0002, 16'h0002);
        wr(`TQM_OFS_TX_SPACE_REQUEST, 16'h0600);
        rchk("space", `TQM_OFS_INTERRUPT_STATUS, 16'h0040, 16'h0040);
        rchk("unarmed", `TQM_OFS_TX_QUEUE_COMMAND, 16'h0002, 16'h0000);
        chk("masked", 16'h0001, {15'h0000, interrupt_out_n});
        wr(`TQM_OFS_INTERRUPT_ENABLE, 16'h0040);
        for (int i = 0; i < 20 && interrupt_out_n !== 1'b0; i++) tick();
        if (interrupt_out_n !== 1'b0) hang("space irq");
        wr(`TQM_OFS_INTERRUPT_STATUS, 16'hFFFF);
        tick();
        chk("cleared", 16'h0001, {15'h0000, interrupt_out_n});
        rchk("isr", `TQM_OFS_INTERRUPT_STATUS, 16'hFFFF, 16'h0000);
        $display("test space done");
        stop_test();
    end
endmodule

// File: verif/tqm_sink.sv
// MAC-side sink that takes stream words at a chosen pace and keeps them.
`timescale 1ns/10ps
module tqm_sink (
    input  wire logic        mclk,
    input  wire logic [1:0]  pace,
    input  wire logic        mac_valid,
    input  wire logic [15:0] mac_data,
    input  wire logic        mac_last,
    output logic             mac_ready
);
    logic [15:0] got [0:1023];
    int          cnt = 0;
    int          last_at = -1;
    logic        tog = 1'b0;

    // Pace 0 stalls, 1 takes every cycle, 2 every other cycle; a stall must not lose words.
    initial mac_ready = 1'b0;
    always @(posedge mclk) begin
        if (mac_valid && mac_ready && cnt < 1024) begin
            got[cnt] = mac_data;
            if (mac_last) begin
                last_at = cnt;
            end
            cnt = cnt + 1;
        end
        tog = !tog;
        #1 mac_ready = (pace == 2'h1) || (pace == 2'h2 && tog);
    end
endmodule

// File: verif/tqm_top_props.sv
// Concurrent checks on the host bus, interrupt pin and MAC stream of tqm_top.
`timescale 1ns/10ps
module tqm_top_props (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [15:0] sd_in,
    input  wire logic [15:0] sd_out,
    input  wire logic        sd_oe_n,
    input  wire logic        cmd,
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        interrupt_out_n,
    input  wire logic [15:0] mac_data,
    input  wire logic        mac_last,
    input  wire logic        mac_valid,
    input  wire logic        mac_ready,
    input  wire logic [8:0]  mac_options
);
    logic       rd_idle_r;
    logic       wr_idle_r;
    logic [5:0] wr_hist_r;
    logic [5:0] end_hist_r;

    // Short histories let a change be traced to a recent host write or frame end.
    always_ff @(posedge mclk) begin
        rd_idle_r  <= rst | cs_n | rd_n;
        wr_idle_r  <= rst | cs_n | wr_n;
        wr_hist_r  <= {wr_hist_r[4:0], !cs_n && !wr_n && wr_idle_r};
        end_hist_r <= {end_hist_r[4:0], mac_valid && mac_ready && mac_last};
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_rd_take;
        !cs_n && !rd_n && rd_idle_r;
    endsequence
    sequence s_last_beat;
        mac_valid && mac_ready && mac_last;
    endsequence

    a_reset_quiet: assert property (disable iff (1'b0)
        rst |=> interrupt_out_n && !mac_valid && mac_options == 9'h000)
        else $error("outputs not idle after reset");
    a_drive_on_read: assert property (sd_oe_n == (cs_n | rd_n))
        else $error("bus drive does not follow read strobe");
    a_read_holds: assert property ($changed(sd_out) |->
        $past(!cs_n && !rd_n && rd_idle_r) || $past(!cs_n && !rd_n && rd_idle_r, 2))
        else $error("read data changed without a read");
    a_stream_stall: assert property (mac_valid && !mac_ready |=>
        mac_valid && $stable(mac_data) && $stable(mac_last))
        else $error("stream word lost during stall");
    a_frame_header_gap: assert property (s_last_beat |=> !mac_valid [*3])
        else $error("next frame data came without header reads");
    a_options_cause: assert property ($changed(mac_options) |-> |wr_hist_r)
        else $error("options changed without host write");
    a_start_enabled: assert property ($rose(mac_valid) |-> mac_options[0])
        else $error("stream started while transmit disabled");
    a_irq_release: assert property ($rose(interrupt_out_n) |-> |wr_hist_r)
        else $error("interrupt released without host write");
    a_irq_cause: assert property ($fell(interrupt_out_n) |->
        |wr_hist_r || |end_hist_r)
        else $error("interrupt raised without a cause");
    a_read_drives: assert property (s_rd_take |-> !sd_oe_n)
        else $error("bus not driven on read");
endmodule

bind tqm_top tqm_top_props u_props (.mclk(mclk), .rst(rst), .sd_in(sd_in), .sd_out(sd_out),
    .sd_oe_n(sd_oe_n), .cmd(cmd), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .interrupt_out_n(interrupt_out_n), .mac_data(mac_data), .mac_last(mac_last),
    .mac_valid(mac_valid), .mac_ready(mac_ready), .mac_options(mac_options));
